//--- hw/adcc_top.sv
// Converter control: registers, conversion sequencer, interval timer and
// result transfer for a 12-bit successive approximation converter core.
// Assumes an APB master on sys_clk, an analog core that raises its end
// flag asynchronously and a memory port that acknowledges on sys_clk.
// How it works
// RL1 - divider code 00/01/10/11 gives 10/4/6/8
// RL2 - sample rate about clock over eighteen
// RL3 - gain code selects quarter, half, unity, double
// RL4 - offset test inverts low twelve result bits
// RL5 - bit 2 selects differential input
// RL6 - bit 1 switches input buffer on
// RL7 - bit 0 powers the converter
// RL8 - end flag synchronised, reads at bit 7
// RL9 - go bit starts, self-clears after a single run or at an unwrapped buffer end, zero stops
// RL10 - thermal sensor power bit, reserved storage
// RL11 - result in low twelve bits, read-only
// RL12 - finished flag set, cleared by control writes
// RL13 - bit 7 enables timed automatic conversions
// RL14 - bit 6 enables continuous conversion
// RL15 - bit 4 gates conversion interrupt; with bits 4 and 3 both clear the code raises irq from the finished flag
// RL16 - bit 3 gates transfer-done interrupt
// RL17 - wrap bit returns pointer to start
// RL18 - bit 0 enables result transfer
// RL19 - software manages buffer and gain choices
// RL20 - end flag: set, W1C, transfer, control write
// RL21 - interval timer: sixteen-clock steps, reload at 256
// RL22 - four sample, one switch, twelve convert
// RL23 - buffer addresses fifteen bits, halfword aligned
// RL24 - each result stored as halfword, pointer+2
`timescale 1ns/1ps
`default_nettype none
module adcc_top
   import adcc_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst,
   // APB slave
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Analog converter core
   input  wire logic              clk_32m_source,
   input  wire logic              raw_conversion_end,
   input  wire logic [11:0]       core_result,
   output adcc_analog_s           analog,
   output logic                   conv_clk,
   output logic                   sample_on,
   output logic                   convert_on,
   // Result transfer to memory
   output adcc_dma_s              dma,
   input  wire logic              dma_ack,
   // Interrupt request
   output logic                   irq
);

   initial begin
      if (ADDR_W < 6 || ADDR_W > 32) begin
         $error("adcc_top: ADDR_W must lie in 6..32");
      end
   end

   function automatic logic [3:0] div_of(input logic [1:0] code);
      case (code)
         2'b00:   div_of = DIV_CODE0;
         2'b01:   div_of = DIV_CODE1;
         2'b10:   div_of = DIV_CODE2;
         default: div_of = DIV_CODE3;
      endcase
   endfunction

   function automatic logic [11:0] present(input logic [11:0] raw, input logic inv);
      present = inv ? ~raw : raw;
   endfunction

   // Registered state
   logic [7:0]          cfg, therm, flag_rsv, ctl, auto_start;
   logic                go, if_end, if_dma, if_eoc;
   logic [11:0]         result;
   logic [ADDR15_W-1:0] beg_addr, end_addr, now_addr;
   adcc_state_e         state;
   logic [3:0]          phase, div_cnt;
   logic [3:0]          auto_pre;
   logic [8:0]          auto_cnt;
   logic                auto_pend;
   logic                s32_a, s32_b, s32_c, eoc_a, eoc_b;

   logic [7:0]          next_cfg, next_therm, next_flag_rsv, next_ctl, next_auto_start;
   logic                next_go, next_if_end, next_if_dma, next_if_eoc;
   logic [11:0]         next_result;
   logic [ADDR15_W-1:0] next_beg_addr, next_end_addr, next_now_addr;
   adcc_state_e         next_state;
   logic [3:0]          next_phase, next_div_cnt, next_auto_pre;
   logic [8:0]          next_auto_cnt;
   logic                next_auto_pend;
   logic [31:0]         next_prdata;
   logic                next_pready, next_pslverr;
   adcc_analog_s        next_analog;
   logic                next_conv_clk, next_sample_on, next_convert_on, next_irq;
   adcc_dma_s           next_dma;

   // Combinational helpers
   logic                access, wr_ev, mapped, src_rise, conv_tick, finish;
   logic [7:0]          offs;
   logic [31:0]         rd_mux;
   logic [ADDR15_W-1:0] adv_addr;

   always_comb begin
      offs      = 8'(paddr[5:0]);
      access    = psel && penable && !pready;
      wr_ev     = psel && penable && pready && pwrite && !pslverr;
      src_rise  = s32_b && !s32_c;
      conv_tick = src_rise && !conv_clk && (div_cnt == 4'(div_of(cfg[7:6]) >> 1) - 4'h1);
      adv_addr  = ADDR15_W'(now_addr + 15'h0002); // RL24
      mapped    = (paddr[1:0] == 2'b00) && (offs <= OFS_TOUCH_CONVERT)
                  && (ADDR_W < 7 || paddr[ADDR_W-1:6] == '0);
      rd_mux    = 32'h0000_0000;
      unique case (offs)
         OFS_CONVERTER_CONFIG:   rd_mux[7:0] = cfg;
         OFS_CONVERSION_CONTROL: rd_mux[7:0] = {eoc_b, 6'h00, go}; // RL8
         OFS_THERMAL_SENSOR:     rd_mux[7:0] = therm;
         OFS_CONVERSION_RESULT:  rd_mux[11:0] = result; // RL11
         OFS_CONV_DONE_FLAG:     rd_mux[7:0] = {if_eoc, flag_rsv[6:0]};
         OFS_TRANSFER_IRQ_CTRL:  rd_mux[7:0] = ctl;
         OFS_TRANSFER_IRQ_FLAGS: rd_mux[7:0] = {3'h0, if_end, if_dma, 3'h0};
         OFS_AUTO_INTERVAL:      rd_mux[7:0] = auto_start;
         OFS_TRANSFER_START:     rd_mux[14:0] = beg_addr;
         OFS_TRANSFER_END:       rd_mux[14:0] = end_addr;
         OFS_TRANSFER_NOW:       rd_mux[14:0] = now_addr;
         default:                rd_mux = 32'h0000_0000;
      endcase
   end

   always_comb begin
      next_cfg        = cfg;
      next_therm      = therm;
      next_flag_rsv   = flag_rsv;
      next_ctl        = ctl;
      next_auto_start = auto_start;
      next_go         = go;
      next_if_end     = if_end;
      next_if_dma     = if_dma;
      next_if_eoc     = if_eoc;
      next_result     = result;
      next_beg_addr   = beg_addr;
      next_end_addr   = end_addr;
      next_now_addr   = now_addr;
      next_state      = state;
      next_phase      = phase;
      next_div_cnt    = div_cnt;
      next_auto_pre   = auto_pre;
      next_auto_cnt   = auto_cnt;
      next_auto_pend  = auto_pend;
      next_dma        = dma;
      next_conv_clk   = conv_clk;
      finish          = 1'b0;

      // APB: one wait state; read data is loaded while pready is low
      next_pready  = access;
      next_prdata  = access ? rd_mux : prdata;
      next_pslverr = access && !mapped;

      // Converter clock from the 32 MHz source, half period per toggle
      if (src_rise) begin
         if (div_cnt == 4'(div_of(cfg[7:6]) >> 1) - 4'h1) begin // RL1
            next_div_cnt  = 4'h0;
            next_conv_clk = !conv_clk;
         end else begin
            next_div_cnt = div_cnt + 4'h1;
         end
      end
      if (!cfg[CFG_PWR_BIT]) begin
         next_div_cnt  = 4'h0;
         next_conv_clk = 1'b0;
      end

      // Interval timer for automatic conversions
      if (ctl[CTL_AUTO_BIT]) begin // RL13
         next_auto_pre = auto_pre + 4'h1;
         if (auto_pre == AUTO_STEP_LAST) begin // RL21
            if (auto_cnt + 9'h001 == AUTO_WRAP) begin
               next_auto_cnt  = {1'b0, auto_start};
               next_auto_pend = 1'b1;
            end else begin
               next_auto_cnt = auto_cnt + 9'h001;
            end
         end
      end else begin
         next_auto_pre  = 4'h0;
         next_auto_cnt  = {1'b0, auto_start};
         next_auto_pend = 1'b0;
      end

      // Conversion sequencer, advanced on converter clock ticks
      unique case (state)
         ST_IDLE: begin
            if (go && cfg[CFG_PWR_BIT] && (!ctl[CTL_AUTO_BIT] || auto_pend)) begin
               next_state     = ST_SAMPLE;
               next_phase     = 4'h0;
               next_auto_pend = 1'b0;
            end
         end
         ST_SAMPLE, ST_SWITCH, ST_CONVERT, ST_GAP: begin
            if (conv_tick) begin
               next_phase = phase + 4'h1;
               if (state == ST_SAMPLE && phase == SAMPLE_CLOCKS - 4'h1) begin        // RL22
                  next_state = ST_SWITCH;
                  next_phase = 4'h0;
               end else if (state == ST_SWITCH && phase == SWITCH_CLOCKS - 4'h1) begin
                  next_state = ST_CONVERT;
                  next_phase = 4'h0;
               end else if (state == ST_CONVERT && phase == CONVERT_CLOCKS - 4'h1) begin
                  next_state = ST_WAIT_END;
                  next_phase = 4'h0;
               end else if (state == ST_GAP && phase == GAP_CLOCKS - 4'h1) begin     // RL2
                  next_state = ST_SAMPLE;
                  next_phase = 4'h0;
               end
            end
         end
         ST_WAIT_END: begin
            if (eoc_b) begin // RL8
               finish      = 1'b1;
               next_result = present(core_result, cfg[CFG_OFS_BIT]); // RL4
               next_phase  = 4'h0;
               if (ctl[CTL_CONT_BIT]) begin // RL14
                  next_state = ST_GAP;
               end else begin
                  next_state = ST_IDLE;
                  if (!ctl[CTL_AUTO_BIT]) begin
                     next_go = 1'b0; // RL9
                  end
               end
            end
         end
      endcase

      // Register writes land before hardware events so that a set wins
      if (wr_ev) begin
         unique case (offs)
            OFS_CONVERTER_CONFIG: next_cfg = pwdata[7:0];        // RL1 RL3 RL5 RL6 RL7
            OFS_CONVERSION_CONTROL: begin
               next_go     = pwdata[CONV_GO_BIT]; // RL9
               next_if_eoc = 1'b0; // RL12
               next_if_end = 1'b0; // RL20
            end
            OFS_THERMAL_SENSOR:    next_therm = pwdata[7:0]; // RL10
            OFS_CONV_DONE_FLAG:    next_flag_rsv = {1'b0, pwdata[6:0]};
            OFS_TRANSFER_IRQ_CTRL: next_ctl = pwdata[7:0] & CTL_WRITE_MASK;
            OFS_TRANSFER_IRQ_FLAGS: begin
               if (pwdata[IF_END_BIT]) begin
                  next_if_end = 1'b0; // RL20
               end
               if (pwdata[IF_DMA_BIT]) begin
                  next_if_dma = 1'b0;
               end
            end
            OFS_AUTO_INTERVAL:  next_auto_start = pwdata[7:0];
            OFS_TRANSFER_START: begin
               next_beg_addr = {pwdata[14:1], 1'b0}; // RL23
               next_now_addr = {pwdata[14:1], 1'b0};
            end
            OFS_TRANSFER_END:   next_end_addr = {pwdata[14:1], 1'b0};
            OFS_TOUCH_CONVERT:  next_if_eoc = 1'b0; // RL12
            default: begin
            end
         endcase
      end

      // Stopping the go bit abandons any conversion in flight
      if (!next_go && state != ST_IDLE && !finish) begin
         next_state = ST_IDLE;
         next_phase = 4'h0;
      end

      // Result transfer: a taken request clears the end flag
      if (dma.req && dma_ack) begin
         next_dma.req = 1'b0;
         next_if_end  = 1'b0; // RL20
         if (adv_addr == end_addr) begin
            if (ctl[CTL_WRAP_BIT]) begin // RL17
               next_now_addr = beg_addr;
            end else begin
               next_now_addr = adv_addr;
               next_if_dma   = 1'b1;
               next_go       = 1'b0; // RL9
               next_state    = ST_IDLE;
            end
         end else begin
            next_now_addr = adv_addr; // RL24
         end
      end

      if (finish) begin
         next_if_eoc = 1'b1; // RL12
         next_if_end = 1'b1; // RL20
         if (ctl[CTL_DMA_BIT]) begin // RL18
            next_dma.req  = 1'b1;
            next_dma.addr = now_addr;
            next_dma.data = {4'h0, next_result}; // RL24
         end
      end

      next_analog.converter_power_on   = cfg[CFG_PWR_BIT]; // RL7
      next_analog.input_buffer_on      = cfg[CFG_BUF_BIT]; // RL6
      next_analog.differential_select  = cfg[CFG_DIFF_BIT]; // RL5
      next_analog.input_gain_select    = cfg[CFG_GAIN_LSB +: 2]; // RL3
      next_analog.thermal_sensor_power = therm[THERM_PWR_BIT]; // RL10
      next_sample_on  = (next_state == ST_SAMPLE);
      next_convert_on = (next_state == ST_SWITCH) || (next_state == ST_CONVERT)
                        || (next_state == ST_WAIT_END);
      next_irq = (ctl[CTL_IE_EOC_BIT] && next_if_end) // RL15
                 || (ctl[CTL_IE_DMA_BIT] && next_if_dma) // RL16
                 || (!ctl[CTL_IE_EOC_BIT] && !ctl[CTL_IE_DMA_BIT] && next_if_eoc);
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s32_a      <= 1'b0;
         s32_b      <= 1'b0;
         s32_c      <= 1'b0;
         eoc_a      <= 1'b0;
         eoc_b      <= 1'b0;
         cfg        <= RST_CONVERTER_CONFIG;
         therm      <= RST_BYTE;
         flag_rsv   <= RST_BYTE;
         ctl        <= RST_BYTE;
         auto_start <= RST_BYTE;
         go         <= 1'b0;
         if_end     <= 1'b0;
         if_dma     <= 1'b0;
         if_eoc     <= 1'b0;
         result     <= 12'h000;
         beg_addr   <= 15'h0000;
         end_addr   <= 15'h0000;
         now_addr   <= 15'h0000;
         state      <= ST_IDLE;
         phase      <= 4'h0;
         div_cnt    <= 4'h0;
         auto_pre   <= 4'h0;
         auto_cnt   <= 9'h000;
         auto_pend  <= 1'b0;
         prdata     <= 32'h0000_0000;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         analog     <= '0;
         conv_clk   <= 1'b0;
         sample_on  <= 1'b0;
         convert_on <= 1'b0;
         dma        <= '0;
         irq        <= 1'b0;
      end else begin
         // Source clock and end flag cross in by two flops first
         s32_a      <= clk_32m_source;
         s32_b      <= s32_a;
         s32_c      <= s32_b;
         eoc_a      <= raw_conversion_end;
         eoc_b      <= eoc_a;                                                        // RL8
         cfg        <= next_cfg;
         therm      <= next_therm;
         flag_rsv   <= next_flag_rsv;
         ctl        <= next_ctl;
         auto_start <= next_auto_start;
         go         <= next_go;
         if_end     <= next_if_end;
         if_dma     <= next_if_dma;
         if_eoc     <= next_if_eoc;
         result     <= next_result;
         beg_addr   <= next_beg_addr;
         end_addr   <= next_end_addr;
         now_addr   <= next_now_addr;
         state      <= next_state;
         phase      <= next_phase;
         div_cnt    <= next_div_cnt;
         auto_pre   <= next_auto_pre;
         auto_cnt   <= next_auto_cnt;
         auto_pend  <= next_auto_pend;
         prdata     <= next_prdata;
         pready     <= next_pready;
         pslverr    <= next_pslverr;
         analog     <= next_analog;
         conv_clk   <= next_conv_clk;
         sample_on  <= next_sample_on;
         convert_on <= next_convert_on;
         dma        <= next_dma;
         irq        <= next_irq;
      end
   end

endmodule // adcc_top
`default_nettype wire

//--- shared/adcc_pkg.sv
// Constants, register map and carrier types of the converter control block.
// Assumes a 32-bit APB slave with one aligned word per register.
package adcc_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CONVERTER_CONFIG   = 8'h00;
   localparam logic [7:0] OFS_CONVERSION_CONTROL = 8'h04;
   localparam logic [7:0] OFS_THERMAL_SENSOR     = 8'h08;
   localparam logic [7:0] OFS_CONVERSION_RESULT  = 8'h0C;
   localparam logic [7:0] OFS_CONV_DONE_FLAG     = 8'h10;
   localparam logic [7:0] OFS_TRANSFER_IRQ_CTRL  = 8'h14;
   localparam logic [7:0] OFS_TRANSFER_IRQ_FLAGS = 8'h18;
   localparam logic [7:0] OFS_AUTO_INTERVAL      = 8'h1C;
   localparam logic [7:0] OFS_TRANSFER_START     = 8'h20;
   localparam logic [7:0] OFS_TRANSFER_END       = 8'h24;
   localparam logic [7:0] OFS_TRANSFER_NOW       = 8'h28;
   localparam logic [7:0] OFS_TOUCH_CONVERT      = 8'h2C;

   // Reset values
   localparam logic [7:0] RST_CONVERTER_CONFIG = 8'hA0;
   localparam logic [7:0] RST_BYTE             = 8'h00;

   // converter_config fields
   localparam int CFG_DIV_LSB  = 6;
   localparam int CFG_GAIN_LSB = 4;
   localparam int CFG_OFS_BIT  = 3;
   localparam int CFG_DIFF_BIT = 2;
   localparam int CFG_BUF_BIT  = 1;
   localparam int CFG_PWR_BIT  = 0;

   // conversion_control, thermal and flag fields
   localparam int CONV_END_BIT  = 7;
   localparam int CONV_GO_BIT   = 0;
   localparam int THERM_PWR_BIT = 7;
   localparam int DONE_FLAG_BIT = 7;

   // transfer_and_irq_control fields
   localparam int CTL_AUTO_BIT   = 7;
   localparam int CTL_CONT_BIT   = 6;
   localparam int CTL_IE_EOC_BIT = 4;
   localparam int CTL_IE_DMA_BIT = 3;
   localparam int CTL_WRAP_BIT   = 2;
   localparam int CTL_DMA_BIT    = 0;
   localparam logic [7:0] CTL_WRITE_MASK = 8'hDD;

   // Interrupt flag register fields
   localparam int IF_END_BIT = 4;
   localparam int IF_DMA_BIT = 3;

   // Converter clock division factors of the 32 MHz source
   localparam logic [3:0] DIV_CODE0 = 4'hA;
   localparam logic [3:0] DIV_CODE1 = 4'h4;
   localparam logic [3:0] DIV_CODE2 = 4'h6;
   localparam logic [3:0] DIV_CODE3 = 4'h8;

   // Conversion phases in converter clocks
   localparam logic [3:0] SAMPLE_CLOCKS  = 4'h4;
   localparam logic [3:0] SWITCH_CLOCKS  = 4'h1;
   localparam logic [3:0] CONVERT_CLOCKS = 4'hC;
   localparam logic [3:0] GAP_CLOCKS     = 4'h1;

   // Interval timer: steps of 16 system clocks, trigger at 256
   localparam logic [3:0] AUTO_STEP_LAST = 4'hF;
   localparam logic [8:0] AUTO_WRAP      = 9'h100;

   localparam int RESULT_W = 12;
   localparam int ADDR15_W = 15;

   typedef enum logic [2:0] {
      ST_IDLE, ST_SAMPLE, ST_SWITCH, ST_CONVERT, ST_WAIT_END, ST_GAP
   } adcc_state_e;

   typedef struct packed {
      logic       converter_power_on;
      logic       input_buffer_on;
      logic       differential_select;
      logic [1:0] input_gain_select;
      logic       thermal_sensor_power;
   } adcc_analog_s;

   typedef struct packed {
      logic                req;
      logic [ADDR15_W-1:0] addr;
      logic [15:0]         data;
   } adcc_dma_s;

endpackage

//--- verif/adcc_core_model.sv
// Behavioural converter core: end flag and result paced by the converter clock.
// Assumes the sequencer holds sample_on over several converter clocks.
`timescale 1ns/1ps
`default_nettype none
module adcc_core_model (
   // Sequencer side
   input wire logic        conv_clk,
   input wire logic        sample_on,
   input wire logic        convert_on,
   // Stimulus
   input wire logic [11:0] value,
   input wire logic [4:0]  lag,
   // Results
   output logic            raw_conversion_end,
   output logic [11:0]     core_result
);
   int n = 0;
   initial raw_conversion_end = 1'b0;
   initial core_result = 12'hFFF;
   // Result not yet valid while sampling, so show a wrong word there
   always @(posedge conv_clk) begin
      n <= convert_on ? n + 1 : 0;
      if (sample_on) begin
         raw_conversion_end <= 1'b0;
         core_result <= ~value;
      end
      if (convert_on && n + 1 == int'(lag)) begin
         raw_conversion_end <= 1'b1;
         core_result <= value;
      end
   end
endmodule // adcc_core_model
`default_nettype wire

//--- verif/adcc_sva.sv
// Checker of the converter control block, bound to its top module.
// Assumes a bus master that keeps the two-phase handshake.
`timescale 1ns/1ps
`default_nettype none
module adcc_sva
   import adcc_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // Clock, reset and bus
   input wire logic              sys_clk,
   input wire logic              rst,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   // Converter core side
   input wire logic              clk_32m_source,
   input wire logic              raw_conversion_end,
   input wire logic [11:0]       core_result,
   input wire adcc_analog_s      analog,
   input wire logic              conv_clk,
   input wire logic              sample_on,
   input wire logic              convert_on,
   // Transfer and interrupt
   input wire adcc_dma_s         dma,
   input wire logic              dma_ack,
   input wire logic              irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("bus answer not one wait state");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_gain_reset: assert property ($fell(rst) |=> analog.input_gain_select == 2'b10)
      else $error("gain not unity after reset");
   a_clk_off: assert property ((!analog.converter_power_on) [*3] |-> !conv_clk)
      else $error("converter clock runs while powered down");
   a_sample_power: assert property ($rose(sample_on) |-> analog.converter_power_on)
      else $error("sampling while powered down");
   a_phase_excl: assert property (!(sample_on && convert_on))
      else $error("sample and convert overlap");
   a_phase_order: assert property ($rose(convert_on) |-> $past(sample_on))
      else $error("convert phase without sample phase");
   a_dma_hold: assert property (dma.req && !dma_ack |=> dma.req && $stable(dma.addr)
      && $stable(dma.data))
      else $error("transfer request changed before acknowledge");
   a_dma_drop: assert property (dma.req && dma_ack |=> !dma.req)
      else $error("transfer request not dropped");
   a_dma_half: assert property (dma.req |-> dma.data[15:12] == 4'h0 && !dma.addr[0])
      else $error("transfer word malformed");
   c_sample: cover property ($fell(sample_on));
   c_store: cover property (dma.req && dma_ack);
   c_error: cover property (pslverr);
   c_irq: cover property ($rose(irq));
endmodule // adcc_sva
`default_nettype wire

//--- verif/adcc_tb_top.sv
// Testbench of the converter control block: registers, conversions, transfers.
// Assumes the core model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module adcc_tb_top
   import adcc_pkg::*;
;
   logic         sys_clk, rst, psel, penable, pwrite, pready, pslverr, err;
   logic         clk_32m_source, raw_conversion_end, conv_clk, sample_on, convert_on;
   logic         dma_ack, irq;
   logic [7:0]   paddr;
   logic [31:0]  pwdata, prdata, rd;
   logic [11:0]  value, core_result;
   logic [4:0]   lag;
   adcc_analog_s analog;
   adcc_dma_s    dma;
   int           failures, checks, stall;
   int           divs[4] = '{10, 4, 6, 8};
   logic [31:0]  stores[$];
   adcc_top #(.ADDR_W(8)) u_adcc_top (.sys_clk, .rst, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .clk_32m_source, .raw_conversion_end,
      .core_result, .analog, .conv_clk, .sample_on, .convert_on, .dma, .dma_ack, .irq);
   adcc_core_model u_adcc_core_model (.conv_clk, .sample_on, .convert_on, .value, .lag,
      .raw_conversion_end, .core_result);
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      clk_32m_source = 1'b0;
      forever #15.625 clk_32m_source = ~clk_32m_source;
   end
   // Memory side stalls four cycles before taking each store
   always @(posedge sys_clk) begin
      stall <= (dma.req && !dma_ack) ? stall + 1 : 0;
      dma_ack <= dma.req && !dma_ack && stall == 3;
      if (dma.req && dma_ack)
         stores.push_back({1'b0, dma.addr, dma.data});
   end
   task automatic results();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic bad(input string m);
      failures++;
      $display("MISMATCH %0t %s", $time, m);
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
         bad($sformatf("got %h expected %h", got, exp));
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      cmp(rd, exp);
   endtask
   task automatic period(input int div);
      realtime t0;
      repeat (2) @(posedge conv_clk);
      t0 = $realtime;
      repeat (4) @(posedge conv_clk);
      checks++;
      if ($realtime - t0 > 125.0 * div + 17.0 || $realtime - t0 < 125.0 * div - 17.0)
         bad("converter clock period");
   endtask
   // Starts one run and polls the go bit until it clears itself
   task automatic convert(input logic [11:0] v);
      value <= v;
      apb(1'b1, OFS_CONVERSION_CONTROL, 32'h1);
      // A stale end flag from the last run drops only during sampling
      @(negedge sample_on);
      rchk(OFS_CONVERSION_CONTROL, 32'h1);
      do apb(1'b0, OFS_CONVERSION_CONTROL, 32'h0); while (rd[0] !== 1'b0);
      cmp(rd, 32'h80);
   endtask
   initial begin
      int k;
      {rst, psel, penable, pwrite, paddr, pwdata, dma_ack, stall} = {1'b1, 76'h0};
      {value, lag, failures, checks} = {12'h0, 5'hD, 64'h0};
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      rchk(OFS_CONVERTER_CONFIG, 32'hA0);
      rchk(OFS_CONVERSION_CONTROL, 32'h0);
      rchk(OFS_TRANSFER_IRQ_CTRL, 32'h0);
      cmp({26'h0, analog}, 32'h4);
      apb(1'b1, OFS_THERMAL_SENSOR, 32'hFF);
      rchk(OFS_THERMAL_SENSOR, 32'hFF);
      apb(1'b1, 8'h30, 32'h0);
      cmp({31'h0, err}, 32'h1);
      foreach (divs[i]) begin
         apb(1'b1, OFS_CONVERTER_CONFIG, {24'h0, i[1:0], i[1:0], 4'h7});
         period(divs[i]);
         cmp({26'h0, analog}, {26'h0, 3'b111, i[1:0], 1'b1});
      end
      apb(1'b1, OFS_CONVERTER_CONFIG, 32'h61);
      convert(12'h573);
      rchk(OFS_CONVERSION_RESULT, 32'h573);
      rchk(OFS_CONV_DONE_FLAG, 32'h80);
      rchk(OFS_TRANSFER_IRQ_FLAGS, 32'h10);
      cmp({31'h0, irq}, 32'h1);
      apb(1'b1, OFS_TRANSFER_IRQ_CTRL, 32'h08);
      rchk(OFS_TRANSFER_IRQ_CTRL, 32'h08);
      cmp({31'h0, irq}, 32'h0);
      apb(1'b1, OFS_TRANSFER_IRQ_CTRL, 32'h10);
      rchk(OFS_CONVERSION_RESULT, 32'h573);
      cmp({31'h0, irq}, 32'h1);
      apb(1'b1, OFS_TRANSFER_IRQ_FLAGS, 32'h10);
      rchk(OFS_TRANSFER_IRQ_FLAGS, 32'h0);
      cmp({31'h0, irq}, 32'h0);
      apb(1'b1, OFS_CONVERSION_RESULT, 32'hFFFF);
      rchk(OFS_CONVERSION_RESULT, 32'h573);
      apb(1'b1, OFS_TOUCH_CONVERT, 32'h0);
      rchk(OFS_CONV_DONE_FLAG, 32'h0);
      lag <= 5'h14;
      apb(1'b1, OFS_CONVERTER_CONFIG, 32'h69);
      convert(12'h573);
      rchk(OFS_CONVERSION_RESULT, 32'hA8C);
      apb(1'b1, OFS_CONVERSION_CONTROL, 32'h0);
      rchk(OFS_CONV_DONE_FLAG, 32'h0);
      rchk(OFS_TRANSFER_IRQ_FLAGS, 32'h0);
      apb(1'b1, OFS_TRANSFER_START, 32'h100);
      apb(1'b1, OFS_TRANSFER_END, 32'h104);
      apb(1'b1, OFS_TRANSFER_IRQ_CTRL, 32'h49);
      convert(12'h2A5);
      cmp(stores.size(), 32'h2);
      cmp(stores[0], 32'h01000D5A);
      cmp(stores[1], 32'h01020D5A);
      rchk(OFS_TRANSFER_IRQ_FLAGS, 32'h08);
      cmp({31'h0, irq}, 32'h1);
      rchk(OFS_TRANSFER_NOW, 32'h104);
      stores.delete();
      apb(1'b1, OFS_TRANSFER_START, 32'h100);
      apb(1'b1, OFS_TRANSFER_IRQ_CTRL, 32'h4D);
      apb(1'b1, OFS_CONVERSION_CONTROL, 32'h1);
      k = 0;
      while (stores.size() < 3 && k < 3000) begin
         @(posedge sys_clk);
         k++;
      end
      @(negedge sample_on);
      apb(1'b1, OFS_CONVERSION_CONTROL, 32'h0);
      cmp(stores[2], 32'h01000D5A);
      rchk(OFS_CONVERSION_CONTROL, 32'h0);
      results();
   end
   initial begin
      repeat (40000) @(posedge sys_clk);
      bad("timeout");
      results();
   end
endmodule // adcc_tb_top
bind adcc_top adcc_sva #(.ADDR_W(ADDR_W)) u_adcc_sva (.sys_clk, .rst, .paddr, .psel,
   .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .clk_32m_source,
   .raw_conversion_end, .core_result, .analog, .conv_clk, .sample_on, .convert_on,
   .dma, .dma_ack, .irq);
`default_nettype wire
